// File: hdl/cpc_map.svh
`ifndef CPC_MAP_SVH
`define CPC_MAP_SVH
// Register byte offsets
`define CPC_CTRL0_OFS 4'h0
`define CPC_CTRL1_OFS 4'h1
`define CPC_INSEL0_OFS 4'h2
`define CPC_INSEL1_OFS 4'h3
`define CPC_PINOUT_OFS 4'h4
`define CPC_SCALER_OFS 4'h5
`define CPC_WINCTL_OFS 4'h6
`define CPC_STATUS_OFS 4'h7
`define CPC_CURR_OFS 4'h8
`define CPC_CURRENT_TRIM_OFS 4'h9
// Writable masks, reserved bits held at zero
`define CPC_CTRL_MASK 8'hF7
`define CPC_INSEL_MASK 8'h3F
`define CPC_PINOUT_MASK 8'h03
`define CPC_SCALER_MASK 8'h3F
`define CPC_WINCTL_MASK 8'h1F
`define CPC_CURR_MASK 8'hC3
`define CPC_CURRENT_TRIM_MASK 8'h0F
// Field positions and register reset value
`define CPC_WIN_EN_BIT 4
`define CPC_CURR_EN_BIT 7
`define CPC_CURR_COMB_BIT 6
`define CPC_WFLAG_BIT 2
`define CPC_RESET_VAL 8'h00
// Positive and negative select codes
`define CPC_NEG_BANDGAP 3'h6
`define CPC_NEG_SCALER 3'h7
`define CPC_POS_RSVD 3'h7
`define CPC_NEG_RSVD 3'h5
`endif

// File: hdl/cpc_pkg.sv
package cpc_pkg;
  typedef enum logic [1:0] {
    CPC_EDGE_TOGGLE = 2'h0,
    CPC_EDGE_RSVD = 2'h1,
    CPC_EDGE_FALL = 2'h2,
    CPC_EDGE_RISE = 2'h3
  } cpc_edge_t;
  typedef enum logic [1:0] {
    CPC_WIN_ABOVE = 2'h0,
    CPC_WIN_INSIDE = 2'h1,
    CPC_WIN_BELOW = 2'h2,
    CPC_WIN_OUTSIDE = 2'h3
  } cpc_win_t;
  typedef enum logic [3:0] {
    CPC_WS_IDLE = 4'h1,
    CPC_WS_ABOVE = 4'h2,
    CPC_WS_INSIDE = 4'h4,
    CPC_WS_BELOW = 4'h8
  } cpc_window_state_t;
endpackage : cpc_pkg

// File: hdl/cpc_sync.sv
module cpc_sync
  import cpc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic din,
  output logic dout
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  // Three stages; change accepted when stage two and three agree
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
      begin
        dout <= s3_q;
      end
    end
  end
endmodule : cpc_sync

// File: hdl/cpc_edge.sv
module cpc_edge
  import cpc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic enable,
  input wire logic level,
  input wire cpc_edge_t mode,
  output logic event_pulse
);
  logic prev_q;
  logic rise;
  logic fall;
  assign rise = level & ~prev_q;
  assign fall = ~level & prev_q;
  // Edge event, raised whatever the interrupt level
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      prev_q <= 1'b0;
      event_pulse <= 1'b0;
    end
    else
    begin
      prev_q <= level;
      case (mode)
        CPC_EDGE_TOGGLE: event_pulse <= enable & (rise | fall);
        CPC_EDGE_FALL: event_pulse <= enable & fall;
        CPC_EDGE_RISE: event_pulse <= enable & rise;
        default: event_pulse <= 1'b0;
      endcase
    end
  end
endmodule : cpc_edge

// File: hdl/cpc_top.sv
// Contract
// - comparator n active only while its enable bit is one.
// - positive select bits 5:3, codes 0-6 pick pins 0-6, 7 reserved.
// - negative select bits 2:0: pins 0,1,3,5,7, reserved, bandgap, scaler.
// - comparator one pin output bit drives its result onto pin 6.
// - comparator zero pin output bit drives its result onto pin 7.
// - scaler output is supply times (factor plus one) over 64.
// - window mode only while window enable bit 4 is set.
// - window condition: above, inside, below, outside.
// - window level bits 1:0 enable window interrupt and pick priority.
// - status bits 7:6 report window state in window mode.
// - status bits 5 and 4 show comparator one and zero outputs.
// - window flag bit 2 set on condition, cleared by vector or one.
// - comparator flags bits 1:0 set on edge, cleared by vector or one.
// - current control bit 7 turns current source on.
// - combine bit 6 merges sources, doubling each output current.
// - current output enable routes current to negative select pin.
// - edge condition: toggle, reserved, falling, rising.
// - events follow the edge condition regardless of interrupt enable.
// - result is one when positive input exceeds negative input.
//
// Strobed register access is this design's own decision.
module cpc_top
  import cpc_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic CMP0_RESULT,
  input wire logic CMP1_RESULT,
  input wire logic VECT_ACK0,
  input wire logic VECT_ACK1,
  input wire logic VECT_ACKW,
  output logic [1:0] CMP_ENABLE,
  output logic [2:0] CMP0_POS_SEL,
  output logic [2:0] CMP0_NEG_SEL,
  output logic [2:0] CMP1_POS_SEL,
  output logic [2:0] CMP1_NEG_SEL,
  output logic [1:0] CMP0_HYST,
  output logic [1:0] CMP1_HYST,
  output logic [5:0] SCALE_FACTOR,
  output logic PIN6_OUT,
  output logic PIN6_OE,
  output logic PIN7_OUT,
  output logic PIN7_OE,
  output logic CURR_ENABLE,
  output logic CURR_COMBINE,
  output logic [1:0] CURR_OUT_EN,
  output logic [3:0] CURR_TRIM,
  output logic [1:0] EVENT_CMP,
  output logic EVENT_WIN,
  output logic [1:0] IRQ0_LEVEL,
  output logic [1:0] IRQ1_LEVEL,
  output logic [1:0] IRQW_LEVEL
);
`include "cpc_map.svh"
  logic [7:0] ctrl0_q;
  logic [7:0] ctrl1_q;
  logic [7:0] insel0_q;
  logic [7:0] insel1_q;
  logic [7:0] pinout_q;
  logic [7:0] scaler_q;
  logic [7:0] winctl_q;
  logic [7:0] curr_q;
  logic [7:0] current_trim_q;
  logic [2:0] flags_q;
  logic cmp0_s;
  logic cmp1_s;
  logic [1:0] cmp_ev;
  logic win_on;
  cpc_win_t win_now;
  cpc_window_state_t ws_q;
  cpc_window_state_t ws_d;
  logic win_ev;
  logic [2:0] clr;
  logic [7:0] status;

  // Result pins arrive from analog cores, so they are synchronised
  cpc_sync u_sync0 (.clk(REF_CLK), .nrst(NRST), .din(CMP0_RESULT), .dout(cmp0_s));
  cpc_sync u_sync1 (.clk(REF_CLK), .nrst(NRST), .din(CMP1_RESULT), .dout(cmp1_s));

  // Per-comparator edge events
  cpc_edge u_edge0 (.clk(REF_CLK), .nrst(NRST), .enable(ctrl0_q[0]), .level(cmp0_s),
    .mode(cpc_edge_t'(ctrl0_q[7:6])), .event_pulse(cmp_ev[0]));
  cpc_edge u_edge1 (.clk(REF_CLK), .nrst(NRST), .enable(ctrl1_q[0]), .level(cmp1_s),
    .mode(cpc_edge_t'(ctrl1_q[7:6])), .event_pulse(cmp_ev[1]));

  // Control register writes, reserved bits masked off
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      ctrl0_q <= `CPC_RESET_VAL;
      ctrl1_q <= `CPC_RESET_VAL;
      insel0_q <= `CPC_RESET_VAL;
      insel1_q <= `CPC_RESET_VAL;
      pinout_q <= `CPC_RESET_VAL;
      scaler_q <= `CPC_RESET_VAL;
      winctl_q <= `CPC_RESET_VAL;
      curr_q <= `CPC_RESET_VAL;
      current_trim_q <= `CPC_RESET_VAL;
    end
    else if (WR)
    begin
      if (ADDR == `CPC_CTRL0_OFS)
        ctrl0_q <= WDATA & `CPC_CTRL_MASK;
      else if (ADDR == `CPC_CTRL1_OFS)
        ctrl1_q <= WDATA & `CPC_CTRL_MASK;
      else if (ADDR == `CPC_INSEL0_OFS)
        insel0_q <= WDATA & `CPC_INSEL_MASK;
      else if (ADDR == `CPC_INSEL1_OFS)
        insel1_q <= WDATA & `CPC_INSEL_MASK;
      else if (ADDR == `CPC_PINOUT_OFS)
        pinout_q <= WDATA & `CPC_PINOUT_MASK;
      else if (ADDR == `CPC_SCALER_OFS)
        scaler_q <= WDATA & `CPC_SCALER_MASK;
      else if (ADDR == `CPC_WINCTL_OFS)
        winctl_q <= WDATA & `CPC_WINCTL_MASK;
      else if (ADDR == `CPC_CURR_OFS)
        curr_q <= WDATA & `CPC_CURR_MASK;
      else if (ADDR == `CPC_CURRENT_TRIM_OFS)
        current_trim_q <= WDATA & `CPC_CURRENT_TRIM_MASK;
    end
  end

  // Window classification: comparator zero upper, comparator one lower
  assign win_on = winctl_q[`CPC_WIN_EN_BIT] & ctrl0_q[0] & ctrl1_q[0];
  always_comb
  begin
    if (cmp0_s)
      win_now = CPC_WIN_ABOVE;
    else if (cmp1_s)
      win_now = CPC_WIN_INSIDE;
    else
      win_now = CPC_WIN_BELOW;
  end

  // Window state tracker, idle outside window mode
  always_comb
  begin
    ws_d = ws_q;
    case (ws_q)
      CPC_WS_IDLE,
      CPC_WS_ABOVE,
      CPC_WS_INSIDE,
      CPC_WS_BELOW:
      begin
        if (!win_on)
          ws_d = CPC_WS_IDLE;
        else if (win_now == CPC_WIN_ABOVE)
          ws_d = CPC_WS_ABOVE;
        else if (win_now == CPC_WIN_INSIDE)
          ws_d = CPC_WS_INSIDE;
        else
          ws_d = CPC_WS_BELOW;
      end
      default: ws_d = CPC_WS_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
      ws_q <= CPC_WS_IDLE;
    else
      ws_q <= ws_d;
  end

  // Window event on entry to the configured condition
  always_comb
  begin
    win_ev = 1'b0;
    if (ws_d != ws_q && ws_d != CPC_WS_IDLE)
    begin
      case (cpc_win_t'(winctl_q[3:2]))
        CPC_WIN_ABOVE: win_ev = (ws_d == CPC_WS_ABOVE);
        CPC_WIN_INSIDE: win_ev = (ws_d == CPC_WS_INSIDE);
        CPC_WIN_BELOW: win_ev = (ws_d == CPC_WS_BELOW);
        default: win_ev = (ws_d != CPC_WS_INSIDE) && (ws_q == CPC_WS_INSIDE
          || ws_q == CPC_WS_IDLE);
      endcase
    end
  end

  // Flag clears: vector acknowledge or write of one
  assign clr[0] = VECT_ACK0 | (WR && ADDR == `CPC_STATUS_OFS && WDATA[0]);
  assign clr[1] = VECT_ACK1 | (WR && ADDR == `CPC_STATUS_OFS && WDATA[1]);
  assign clr[2] = VECT_ACKW | (WR && ADDR == `CPC_STATUS_OFS && WDATA[`CPC_WFLAG_BIT]);

  // Sticky flags, a set in the clear cycle wins
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
      flags_q <= 3'h0;
    else
    begin
      flags_q[0] <= cmp_ev[0] | (flags_q[0] & ~clr[0]);
      flags_q[1] <= cmp_ev[1] | (flags_q[1] & ~clr[1]);
      flags_q[2] <= (win_ev & (win_on)) | (flags_q[2] & ~clr[2]);
    end
  end

  // Window state shown only in window mode
  always_comb
  begin
    status = {2'h0, cmp1_s, cmp0_s, 1'b0, flags_q};
    if (win_on)
      status[7:6] = win_now;
  end

  // Read data in the cycle after the read strobe
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
      RDATA <= 8'h00;
    else if (!RD)
      RDATA <= 8'h00;
    else if (ADDR == `CPC_CTRL0_OFS)
      RDATA <= ctrl0_q;
    else if (ADDR == `CPC_CTRL1_OFS)
      RDATA <= ctrl1_q;
    else if (ADDR == `CPC_INSEL0_OFS)
      RDATA <= insel0_q;
    else if (ADDR == `CPC_INSEL1_OFS)
      RDATA <= insel1_q;
    else if (ADDR == `CPC_PINOUT_OFS)
      RDATA <= pinout_q;
    else if (ADDR == `CPC_SCALER_OFS)
      RDATA <= scaler_q;
    else if (ADDR == `CPC_WINCTL_OFS)
      RDATA <= winctl_q;
    else if (ADDR == `CPC_STATUS_OFS)
      RDATA <= status;
    else if (ADDR == `CPC_CURR_OFS)
      RDATA <= curr_q;
    else if (ADDR == `CPC_CURRENT_TRIM_OFS)
      RDATA <= current_trim_q;
    else
      RDATA <= 8'h00;
  end

  // Analog core controls, registered
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      CMP_ENABLE <= 2'h0;
      CMP0_POS_SEL <= 3'h0;
      CMP0_NEG_SEL <= 3'h0;
      CMP1_POS_SEL <= 3'h0;
      CMP1_NEG_SEL <= 3'h0;
      CMP0_HYST <= 2'h0;
      CMP1_HYST <= 2'h0;
      SCALE_FACTOR <= 6'h00;
    end
    else
    begin
      CMP_ENABLE <= {ctrl1_q[0], ctrl0_q[0]};
      CMP0_POS_SEL <= insel0_q[5:3];
      CMP0_NEG_SEL <= insel0_q[2:0];
      CMP1_POS_SEL <= insel1_q[5:3];
      CMP1_NEG_SEL <= insel1_q[2:0];
      CMP0_HYST <= (ctrl0_q[2:1] == 2'h3) ? 2'h0 : ctrl0_q[2:1];
      CMP1_HYST <= (ctrl1_q[2:1] == 2'h3) ? 2'h0 : ctrl1_q[2:1];
      SCALE_FACTOR <= scaler_q[5:0];
    end
  end

  // Pin routing of results and current source
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      PIN6_OUT <= 1'b0;
      PIN6_OE <= 1'b0;
      PIN7_OUT <= 1'b0;
      PIN7_OE <= 1'b0;
      CURR_ENABLE <= 1'b0;
      CURR_COMBINE <= 1'b0;
      CURR_OUT_EN <= 2'h0;
      CURR_TRIM <= 4'h0;
    end
    else
    begin
      PIN6_OE <= pinout_q[1];
      PIN6_OUT <= pinout_q[1] & cmp1_s;
      PIN7_OE <= pinout_q[0];
      PIN7_OUT <= pinout_q[0] & cmp0_s;
      CURR_ENABLE <= curr_q[`CPC_CURR_EN_BIT];
      CURR_COMBINE <= curr_q[`CPC_CURR_COMB_BIT];
      CURR_OUT_EN <= curr_q[1:0];
      CURR_TRIM <= current_trim_q[3:0];
    end
  end

  // Events and interrupt requests
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      EVENT_CMP <= 2'h0;
      EVENT_WIN <= 1'b0;
      IRQ0_LEVEL <= 2'h0;
      IRQ1_LEVEL <= 2'h0;
      IRQW_LEVEL <= 2'h0;
    end
    else
    begin
      EVENT_CMP <= cmp_ev;
      EVENT_WIN <= win_ev & win_on;
      IRQ0_LEVEL <= flags_q[0] ? ctrl0_q[5:4] : 2'h0;
      IRQ1_LEVEL <= flags_q[1] ? ctrl1_q[5:4] : 2'h0;
      IRQW_LEVEL <= flags_q[2] ? winctl_q[1:0] : 2'h0;
    end
  end

  flag_set_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    cmp_ev[0] |=> flags_q[0]) else $error("flag zero not set");
  wflag_clr_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (VECT_ACKW && !(win_ev && win_on)) |=> !flags_q[2]) else $error("window flag kept");
  irq_gate_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (IRQ0_LEVEL != 2'h0) |-> $past(flags_q[0])) else $error("irq without flag");
  pin_route_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    !pinout_q[1] |=> !PIN6_OE) else $error("pin six driven");
  pin7_route_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    pinout_q[0] |=> PIN7_OE && PIN7_OUT == $past(cmp0_s)) else $error("pin seven");
  win_off_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    !win_on |-> status[7:6] == 2'h0) else $error("window state leaked");
  cmp_en_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    !ctrl0_q[0] |=> !CMP_ENABLE[0]) else $error("comparator active");
  curr_on_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    curr_q[7] |=> CURR_ENABLE) else $error("current off");
  pin6_drive_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    pinout_q[1] |=> PIN6_OE && PIN6_OUT == $past(cmp1_s)) else $error("pin six");
  irqw_gate_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (IRQW_LEVEL != 2'h0) |-> $past(flags_q[2])) else $error("window irq no flag");
  comb_copy_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    curr_q[6] |=> CURR_COMBINE) else $error("combine off");
endmodule : cpc_top

// File: tb/cpc_analog.sv
module cpc_analog
  import cpc_pkg::*;
(
  input wire logic [7:0] pin_hi,
  input wire logic [1:0] cmp_en,
  input wire logic [2:0] pos0_sel,
  input wire logic [2:0] neg0_sel,
  input wire logic [2:0] pos1_sel,
  input wire logic [2:0] neg1_sel,
  output logic res0,
  output logic res1
);
  timeunit 1ns;
  timeprecision 1ns;

  // Positive input level, reserved code floats low
  function automatic logic pos_lvl(input logic [2:0] s, input logic [7:0] p);
    pos_lvl = (s == 3'h7) ? 1'b0 : p[s];
  endfunction : pos_lvl

  // Negative input level, internal references modelled low
  function automatic logic neg_lvl(input logic [2:0] s, input logic [7:0] p);
    case (s)
      3'h0: neg_lvl = p[0];
      3'h1: neg_lvl = p[1];
      3'h2: neg_lvl = p[3];
      3'h3: neg_lvl = p[5];
      3'h4: neg_lvl = p[7];
      default: neg_lvl = 1'b0;
    endcase
  endfunction : neg_lvl

  // Idle cores stay low; high only when positive exceeds negative
  assign res0 = cmp_en[0] & pos_lvl(pos0_sel, pin_hi) & ~neg_lvl(neg0_sel, pin_hi);
  assign res1 = cmp_en[1] & pos_lvl(pos1_sel, pin_hi) & ~neg_lvl(neg1_sel, pin_hi);
endmodule : cpc_analog

// File: tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] pin_hi = 8'h00;
  logic [2:0] ack = 3'h0;
  logic [7:0] rdata;
  logic res0, res1, p6o, p6e, p7o, p7e, c_en, c_cmb, ev_win;
  logic [1:0] cmp_en, h0, h1, c_oe, ev_cmp, irq0, irq1, irqw;
  logic [2:0] p0, n0, p1, n1;
  logic [5:0] scale;
  logic [3:0] trim;
  logic [7:0] msk [11] = '{8'hF7, 8'hF7, 8'h3F, 8'h3F, 8'h03, 8'h3F, 8'h1F, 8'h00, 8'hC3,
    8'h0F, 8'h00};
  int errors = 0;
  int num_checks = 0;
  int ev0 = 0;
  int ev1 = 0;
  int evw = 0;
  int w1, ww;
  int i, e;
  logic rf, ff;

  always #20 ref_clk = ~ref_clk;

  cpc_top uut(.REF_CLK(ref_clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .CMP0_RESULT(res0), .CMP1_RESULT(res1), .VECT_ACK0(ack[0]),
    .VECT_ACK1(ack[1]), .VECT_ACKW(ack[2]), .CMP_ENABLE(cmp_en), .CMP0_POS_SEL(p0),
    .CMP0_NEG_SEL(n0), .CMP1_POS_SEL(p1), .CMP1_NEG_SEL(n1), .CMP0_HYST(h0), .CMP1_HYST(h1),
    .SCALE_FACTOR(scale), .PIN6_OUT(p6o), .PIN6_OE(p6e), .PIN7_OUT(p7o), .PIN7_OE(p7e),
    .CURR_ENABLE(c_en), .CURR_COMBINE(c_cmb), .CURR_OUT_EN(c_oe), .CURR_TRIM(trim),
    .EVENT_CMP(ev_cmp), .EVENT_WIN(ev_win), .IRQ0_LEVEL(irq0), .IRQ1_LEVEL(irq1),
    .IRQW_LEVEL(irqw));

  cpc_analog model(.pin_hi(pin_hi), .cmp_en(cmp_en), .pos0_sel(p0), .neg0_sel(n0),
    .pos1_sel(p1), .neg1_sel(n1), .res0(res0), .res1(res1));

  // Count comparator and window events
  always @(posedge ref_clk)
  begin
    if (ev_cmp[0] === 1'b1)
      ev0 <= ev0 + 1;
    if (ev_cmp[1] === 1'b1)
      ev1 <= ev1 + 1;
    if (ev_win === 1'b1)
      evw <= evw + 1;
  end

  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    num_checks++;
    if (g !== x)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, input logic [7:0] m, input logic [7:0] x,
    input string n);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    chk(n, x, rdata & m);
  endtask : rd_reg

  task automatic set_pins(input logic [7:0] v);
    @(posedge ref_clk);
    pin_hi <= v;
    tick(12);
  endtask : set_pins

  task automatic pulse(input int k);
    @(posedge ref_clk);
    ack[k] <= 1'b1;
    @(posedge ref_clk);
    ack <= 3'h0;
    tick(2);
  endtask : pulse

  task automatic finish_test;
    if (errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    finish_test();
  end

  // Main sequence
  initial
  begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    for (i = 0; i < 11; i++)
      rd_reg(i[3:0], 8'hFF, 8'h00, "reset value");
    for (i = 0; i < 11; i++)
      if (i != 7)
        wr_reg(i[3:0], msk[i]);
    for (i = 0; i < 11; i++)
      if (i != 7)
        rd_reg(i[3:0], 8'hFF, msk[i], "readback");
    tick(2);
    chk("enable", 8'h03, {6'h00, cmp_en});
    chk("hyst", 8'h00, {4'h0, h1, h0});
    chk("scale", 8'h3F, {2'b00, scale});
    chk("current", 8'hC3, {c_en, c_cmb, 4'h0, c_oe});
    chk("trim", 8'h0F, {4'h0, trim});
    chk("pin oe", 8'h03, {6'h00, p6e, p7e});
    // Every select code on both comparators
    for (i = 0; i < 8; i++)
    begin
      wr_reg(4'h2, {2'b00, i[2:0], ~i[2:0]});
      wr_reg(4'h3, {2'b00, ~i[2:0], i[2:0]});
      tick(2);
      chk("sel0", {2'b00, i[2:0], ~i[2:0]}, {2'b00, p0, n0});
      chk("sel1", {2'b00, ~i[2:0], i[2:0]}, {2'b00, p1, n1});
    end
    // Edge conditions, level field follows the mode
    wr_reg(4'h6, 8'h00);
    wr_reg(4'h2, 8'h08);
    wr_reg(4'h3, 8'h08);
    wr_reg(4'h1, 8'h01);
    for (i = 0; i < 4; i++)
    begin
      rf = (i[0] == i[1]);
      ff = ~i[0];
      wr_reg(4'h0, {i[1:0], i[1:0], 4'h1});
      wr_reg(4'h7, 8'h07);
      tick(2);
      e = ev0;
      set_pins(8'h02);
      chk("pin7", 8'h01, {7'h00, p7o});
      chk("pin6", 8'h01, {7'h00, p6o});
      rd_reg(4'h7, 8'h31, {7'h18, rf}, "rise status");
      chk("irq0", rf ? {6'h00, i[1:0]} : 8'h00, {6'h00, irq0});
      wr_reg(4'h7, 8'h01);
      set_pins(8'h00);
      rd_reg(4'h7, 8'h31, {7'h00, ff}, "fall status");
      pulse(0);
      rd_reg(4'h7, 8'h01, 8'h00, "vector clear");
      chk("events", 8'(rf + ff), 8'(ev0 - e));
    end
    // Window mode
    wr_reg(4'h0, 8'h03);
    wr_reg(4'h1, 8'h15);
    wr_reg(4'h2, 8'h10);
    wr_reg(4'h3, 8'h18);
    wr_reg(4'h7, 8'h07);
    wr_reg(4'h6, 8'h05);
    w1 = ev1;
    ww = evw;
    set_pins(8'h08);
    rd_reg(4'h7, 8'h04, 8'h00, "window off");
    chk("hyst codes", 8'h09, {4'h0, h1, h0});
    chk("irq1", 8'h01, {6'h00, irq1});
    set_pins(8'h00);
    wr_reg(4'h6, 8'h15);
    tick(4);
    rd_reg(4'h7, 8'hC4, 8'h80, "below");
    set_pins(8'h08);
    rd_reg(4'h7, 8'hC4, 8'h44, "inside");
    chk("irqw", 8'h01, {6'h00, irqw});
    wr_reg(4'h7, 8'h04);
    rd_reg(4'h7, 8'h04, 8'h00, "wflag write");
    wr_reg(4'h6, 8'h1E);
    set_pins(8'h0C);
    rd_reg(4'h7, 8'hC4, 8'h04, "above");
    chk("irqw", 8'h02, {6'h00, irqw});
    pulse(2);
    rd_reg(4'h7, 8'h04, 8'h00, "wflag vector");
    wr_reg(4'h6, 8'h12);
    set_pins(8'h08);
    rd_reg(4'h7, 8'hC4, 8'h40, "not above");
    set_pins(8'h0C);
    rd_reg(4'h7, 8'hC4, 8'h04, "above flag");
    chk("irqw above", 8'h02, {6'h00, irqw});
    wr_reg(4'h7, 8'h04);
    wr_reg(4'h6, 8'h18);
    set_pins(8'h00);
    rd_reg(4'h7, 8'hC4, 8'h84, "below flag");
    chk("irqw off", 8'h00, {6'h00, irqw});
    chk("cmp1 events", 8'h04, 8'(ev1 - w1));
    chk("win events", 8'h04, 8'(evw - ww));
    finish_test();
  end
endmodule : tb
